// File: include/ct_pkg.sv
// counter/timer package: offsets, modes, state layout
package ct_pkg;
    localparam logic [3:0] ADDR_PRESET_HIGH = 4'h6;
    localparam logic [3:0] ADDR_PRESET_LOW = 4'h7;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h6;
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h7;
    localparam logic [3:0] ADDR_START_CMD = 4'he;
    localparam logic [3:0] ADDR_STOP_CMD = 4'hf;
    localparam int CTR_READY_BIT = 3;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] PRESET_RESET = 16'h0000;
    localparam logic [3:0] PRESCALE_LAST = 4'hf;
    localparam logic [3:0] PRESCALE_ZERO = 4'h0;
    localparam logic [3:0] PRESCALE_STEP = 4'h1;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    typedef enum logic [2:0] {
        MODE_CNT_EXT = 3'b000,
        MODE_CNT_TX1X = 3'b001,
        MODE_RESERVED = 3'b010,
        MODE_CNT_OSC16 = 3'b011,
        MODE_TMR_EXT = 3'b100,
        MODE_TMR_EXT16 = 3'b101,
        MODE_TMR_OSC = 3'b110,
        MODE_TMR_OSC16 = 3'b111
    } ct_mode_e;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } run_state_e;

    typedef struct packed {
        logic [2:0] sync;
    } edge_state_s;

    typedef struct packed {
        logic [3:0] phase;
    } prescale_state_s;

    typedef struct packed {
        logic [7:0] preset_high;
        logic [7:0] preset_low;
        logic [15:0] count;
        logic [15:0] half_preset;
        run_state_e run;
        logic wave;
        logic ready;
        logic pin;
        logic irq_n;
        logic [7:0] rdata;
    } ct_state_s;
endpackage

// File: rtl/uart_counter_timer.sv
// 16-bit counter/timer of the serial controller
//
// Behaviour
// - write-only preset bytes, reads never return preset
// - timer square wave period twice preset
// - idle until first start read, then runs
// - start restarts timer cycle from preset
// - preset rewrite applies from next half-period
// - ready once per wave cycle; stop clears
// - timer wave drives pin when selected
// - counter decrements from start, ready at zero
// - counter keeps counting until stop command
// - counter pin high counting, low at terminal
// - counter stop halts, pin high, clears ready
// - counter preset used only at next start
// - count readable as high and low bytes
// - mode field selects function and clock
// - timer ready every second zero reach
// - interrupt low when ready and masked in
`timescale 1ns/1ps
module uart_counter_timer
    import ct_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic i_rd_stb,
    input wire logic i_wr_stb,
    input wire logic [7:0] i_wdata,
    input wire logic [2:0] i_mode,
    input wire logic i_pin_is_ct,
    input wire logic i_ready_mask,
    input wire logic i_external_count_input,
    input wire logic i_transmit_1x_clock,
    input wire logic i_oscillator_clock_input,
    output logic [7:0] o_rdata,
    output logic o_counter_ready,
    output logic o_timer_output_pin,
    output logic o_ct_wave,
    output logic o_interrupt_request_n
);
    ct_state_s s_q;
    ct_state_s s_d;
    logic ext_rise;
    logic tx_rise;
    logic osc_rise;
    logic is_timer;
    logic src_level;
    logic src_rise;
    logic tick;
    logic start_cmd;
    logic stop_cmd;

    // every source synced all the time, so a mode switch meets settled stages
    ct_src_edge #(
        .IDLE_LEVEL(1'b0)
    ) i_ext_edge (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_level(i_external_count_input),
        .o_rise(ext_rise)
    );

    ct_src_edge #(
        .IDLE_LEVEL(1'b0)
    ) i_tx_edge (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_level(i_transmit_1x_clock),
        .o_rise(tx_rise)
    );

    ct_src_edge #(
        .IDLE_LEVEL(1'b0)
    ) i_osc_edge (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_level(i_oscillator_clock_input),
        .o_rise(osc_rise)
    );

    assign start_cmd = i_rd_stb && (i_addr == ADDR_START_CMD);
    assign stop_cmd = i_rd_stb && (i_addr == ADDR_STOP_CMD);

    // clock source selection; src_level marks a divide-by-16 source
    always_comb begin
        is_timer = 1'b0;
        src_level = 1'b0;
        src_rise = 1'b0;
        unique case (ct_mode_e'(i_mode))
            MODE_CNT_EXT: begin
                src_rise = ext_rise;
            end
            MODE_CNT_TX1X: begin
                src_rise = tx_rise;
            end
            MODE_RESERVED: begin
                src_rise = 1'b0;
            end
            MODE_CNT_OSC16: begin
                src_rise = osc_rise;
                src_level = 1'b1;
            end
            MODE_TMR_EXT: begin
                is_timer = 1'b1;
                src_rise = ext_rise;
            end
            MODE_TMR_EXT16: begin
                is_timer = 1'b1;
                src_rise = ext_rise;
                src_level = 1'b1;
            end
            MODE_TMR_OSC: begin
                is_timer = 1'b1;
                src_rise = osc_rise;
            end
            MODE_TMR_OSC16: begin
                is_timer = 1'b1;
                src_rise = osc_rise;
                src_level = 1'b1;
            end
        endcase
    end

    // start clears the prescaler so a fresh cycle begins on a whole tick
    ct_prescale i_prescale (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_rise(src_rise),
        .i_div16(src_level),
        .i_clear(start_cmd),
        .o_tick(tick)
    );

    always_comb begin
        logic [15:0] preset;
        s_d = s_q;
        preset = {s_q.preset_high, s_q.preset_low};

        // preset writes; reads of these offsets return count, never preset
        if (i_wr_stb && i_addr == ADDR_PRESET_HIGH) begin
            s_d.preset_high = i_wdata;
        end
        if (i_wr_stb && i_addr == ADDR_PRESET_LOW) begin
            s_d.preset_low = i_wdata;
        end

        unique case (s_q.run)
            ST_IDLE: begin
                if (!is_timer) begin
                    s_d.pin = 1'b1;
                end
            end
            ST_RUN: begin
                if (tick) begin
                    if (is_timer) begin
                        if (s_q.count <= COUNT_ONE) begin
                            // half-period ends: reload with preset now in place
                            s_d.count = preset;
                            s_d.half_preset = preset;
                            s_d.wave = !s_q.wave;
                            if (s_q.wave) begin
                                s_d.ready = 1'b1;
                            end
                        end else begin
                            s_d.count = s_q.count - COUNT_ONE;
                        end
                    end else begin
                        s_d.count = s_q.count - COUNT_ONE;
                        if (s_q.count == COUNT_ONE) begin
                            s_d.ready = 1'b1;
                            s_d.pin = 1'b0;
                        end
                    end
                end
            end
        endcase

        // stop: counter halts, timer keeps running
        if (stop_cmd) begin
            s_d.ready = 1'b0;
            if (!is_timer) begin
                s_d.run = ST_IDLE;
                s_d.pin = 1'b1;
            end
        end
        // start wins over stop only by address, never both at once
        if (start_cmd) begin
            s_d.run = ST_RUN;
            s_d.count = preset;
            s_d.half_preset = preset;
            s_d.wave = 1'b1;
            if (!is_timer) begin
                s_d.pin = 1'b1;
            end
        end

        // live count bytes; host stops first for a coherent pair
        s_d.rdata = RDATA_IDLE;
        if (i_rd_stb && i_addr == ADDR_COUNT_HIGH) begin
            s_d.rdata = s_q.count[15:8];
        end
        if (i_rd_stb && i_addr == ADDR_COUNT_LOW) begin
            s_d.rdata = s_q.count[7:0];
        end

        if (i_pin_is_ct) begin
            s_d.pin = is_timer ? s_d.wave : s_d.pin;
        end
        s_d.irq_n = !(s_d.ready && i_ready_mask);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.run <= ST_IDLE;
            s_q.pin <= 1'b1;
            s_q.wave <= 1'b1;
            s_q.irq_n <= 1'b1;
            s_q.count <= PRESET_RESET;
            s_q.half_preset <= PRESET_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_counter_ready = s_q.ready;
    assign o_timer_output_pin = s_q.pin;
    assign o_ct_wave = s_q.wave;
    assign o_interrupt_request_n = s_q.irq_n;
endmodule

// two-flop synchroniser; the third stage only feeds the rise detect
module ct_src_edge
    import ct_pkg::*;
#(
    parameter logic IDLE_LEVEL = 1'b0
)
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_level,
    output logic o_rise
);
    edge_state_s s_q;
    edge_state_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.sync = {s_q.sync[1:0], i_level};
    end

    // reset to the idle level so no false rise follows reset
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q.sync <= {3{IDLE_LEVEL}};
        end else begin
            s_q <= s_d;
        end
    end

    // stage 0 may be metastable; only stages 1 and 2 are read
    assign o_rise = s_q.sync[1] && !s_q.sync[2];
endmodule

// divide-by-16 prescaler for the slow source modes
module ct_prescale
    import ct_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_rise,
    input wire logic i_div16,
    input wire logic i_clear,
    output logic o_tick
);
    prescale_state_s s_q;
    prescale_state_s s_d;

    always_comb begin
        s_d = s_q;
        if (i_clear) begin
            s_d.phase = PRESCALE_ZERO;
        end else if (i_rise) begin
            s_d.phase = s_q.phase + PRESCALE_STEP;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q.phase <= PRESCALE_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    // undivided modes tick on every rise, phase is then unused
    assign o_tick = i_div16 ? (i_rise && s_q.phase == PRESCALE_LAST) : i_rise;
endmodule

// File: sim/ct_chk.sv
// port checker for the counter/timer
`timescale 1ns/1ps
module ct_chk(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic i_rd_stb,
    input wire logic [2:0] i_mode,
    input wire logic i_pin_is_ct,
    input wire logic i_ready_mask,
    input wire logic [7:0] o_rdata,
    input wire logic o_counter_ready,
    input wire logic o_timer_output_pin,
    input wire logic o_ct_wave,
    input wire logic o_interrupt_request_n
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    AST_RST_IDLE: assert property ($fell(i_rst) |-> o_ct_wave && o_timer_output_pin &&
        !o_counter_ready && o_interrupt_request_n) else $error("bad idle after reset");
    AST_STOP_CLR: assert property (i_rd_stb && i_addr == 4'hf |=> !o_counter_ready)
        else $error("stop left ready set");
    AST_STOP_PIN: assert property (i_rd_stb && i_addr == 4'hf && !i_mode[2] && i_pin_is_ct
        |=> o_timer_output_pin) else $error("stop left pin low");
    AST_TMR_PIN: assert property (i_mode[2] && i_pin_is_ct && $stable(i_mode)
        |-> o_timer_output_pin == o_ct_wave) else $error("pin not wave");
    AST_TMR_READY: assert property (i_mode[2] && $rose(o_counter_ready) |-> $fell(o_ct_wave))
        else $error("ready off wave fall");
    AST_CNT_PIN: assert property (!i_mode[2] && i_pin_is_ct && $rose(o_counter_ready)
        |-> !o_timer_output_pin) else $error("pin high at terminal");
    AST_IRQ_ON: assert property ((o_counter_ready && i_ready_mask)[*2]
        |-> !o_interrupt_request_n) else $error("irq missing");
    AST_IRQ_OFF: assert property ((!o_counter_ready || !i_ready_mask)[*2]
        |-> o_interrupt_request_n) else $error("irq spurious");
    AST_RDATA_IDLE: assert property (!i_rd_stb |=> o_rdata == 8'h00)
        else $error("data without read");
endmodule

bind uart_counter_timer ct_chk i_chk(.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
    .i_rd_stb(i_rd_stb), .i_mode(i_mode), .i_pin_is_ct(i_pin_is_ct),
    .i_ready_mask(i_ready_mask), .o_rdata(o_rdata), .o_counter_ready(o_counter_ready),
    .o_timer_output_pin(o_timer_output_pin), .o_ct_wave(o_ct_wave),
    .o_interrupt_request_n(o_interrupt_request_n));

// File: sim/uart_counter_timer_tb.sv
// self-checking bench for the counter/timer
`timescale 1ns/1ps
module uart_counter_timer_tb;
    import ct_pkg::*;
    logic i_mclk = 0, i_rst = 1, rd = 0, wr = 0, pin_sel = 1, mask = 1, src = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    ct_mode_e mode = MODE_TMR_OSC;
    logic [7:0] rdata;
    logic [7:0] got;
    logic ready, pin, wave, irq_n;
    int n_fail = 0, n_tests = 0, cyc = 0;
    uart_counter_timer i_dut(.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(addr), .i_rd_stb(rd),
        .i_wr_stb(wr), .i_wdata(wdata), .i_mode(mode), .i_pin_is_ct(pin_sel),
        .i_ready_mask(mask), .i_external_count_input(src), .i_transmit_1x_clock(src),
        .i_oscillator_clock_input(src), .o_rdata(rdata), .o_counter_ready(ready),
        .o_timer_output_pin(pin), .o_ct_wave(wave), .o_interrupt_request_n(irq_n));
    initial forever #20 i_mclk = ~i_mclk;
    // one source rise every two cycles, so an undivided tick is two cycles and a divide-by-16 tick is 32
    always @(posedge i_mclk) begin
        src <= #1 ~src;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            close_out;
        end
    end
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        step(1);
        got = rdata;
        wr = 0;
        rd = 0;
        // let an edge pass so the next strobe is a fresh pulse
        step(1);
    endtask
    task half(output int n);
        logic w;
        w = wave;
        n = 0;
        while (wave === w && n < 400) begin
            step(1);
            n++;
        end
    endtask
    task t_timer(input ct_mode_e m, input int k);
        int n;
        mode = m;
        acc(1, ADDR_PRESET_HIGH, 8'h00);
        acc(1, ADDR_PRESET_LOW, 8'h03);
        acc(0, ADDR_START_CMD, 8'h00);
        half(n);
        half(n);
        chk(n, 3 * k);
        chk(pin, wave);
        half(n);
        chk(ready, 1);
        chk(irq_n, 0);
        mask = 0;
        step(2);
        chk(irq_n, 1);
        mask = 1;
        acc(0, ADDR_STOP_CMD, 8'h00);
        chk(ready, 0);
        acc(1, ADDR_PRESET_LOW, 8'h05);
        half(n);
        half(n);
        chk(n, 5 * k);
        if (wave !== 1'b0) half(n);
        acc(0, ADDR_START_CMD, 8'h00);
        chk(wave, 1);
    endtask
    task t_counter(input ct_mode_e m);
        int n;
        logic [7:0] low;
        mode = m;
        acc(0, ADDR_STOP_CMD, 8'h00);
        acc(1, ADDR_PRESET_LOW, 8'h03);
        acc(0, ADDR_START_CMD, 8'h00);
        chk({pin, ready}, 2'b10);
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        chk(pin, 0);
        step(20);
        acc(0, ADDR_STOP_CMD, 8'h00);
        chk({pin, ready}, 2'b10);
        acc(0, ADDR_COUNT_HIGH, 8'h00);
        chk(got, 8'hff);
        acc(0, ADDR_COUNT_LOW, 8'h00);
        low = got;
        acc(1, ADDR_PRESET_LOW, 8'h04);
        step(10);
        acc(0, ADDR_COUNT_LOW, 8'h00);
        chk(got, low);
    endtask
    initial begin
        step(2);
        i_rst = 0;
        step(20);
        chk({wave, ready, irq_n}, 3'b101);
        t_timer(MODE_TMR_OSC, 2);
        t_timer(MODE_TMR_EXT, 2);
        t_timer(MODE_TMR_OSC16, 32);
        t_counter(MODE_CNT_EXT);
        t_counter(MODE_CNT_TX1X);
        close_out;
    end
endmodule
